// ===== hw/sbr_sram_bitband_boot_remap.sv
// SRAM front end with even/odd banks, bit-band alias and boot remap sequencer
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - SRAM decoded at its system base
// - Bit-band alias region at fixed base
// - Alias offset = byte*32 + bit*4
// - Alias access touches one bit atomically
// - Even words one bank, odd words other
// - Read after same-bank write stalls one cycle
// - Write then other-bank read: no wait
// - DMA reaches SRAM only, never ROM/flash
// - ROM decoded at its fixed base
// - Reset overlays ROM onto flash range
// - Boot start: remap cleared, flash at zero
// - Enabled pin match maps ROM, runs loader
// - Erased reset vector maps ROM, loader
// - Otherwise core loads SP, PC from flash
// - Boot pin chosen from any GPIO A-H
module sbr_sram_bitband_boot_remap (
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic cpu_valid, // Core request
    input wire logic cpu_write, // Core write
    input wire logic [31:0] cpu_addr, // Core address
    input wire logic [31:0] cpu_wdata, // Core write data
    output logic cpu_ready, // Core request taken
    output logic [31:0] cpu_rdata, // Core read data
    output logic cpu_rvalid, // Core read data valid
    output logic cpu_err, // Core unmapped access
    output logic cpu_rom_sel, // Core access goes to ROM
    output logic cpu_flash_sel, // Core access goes to flash
    input wire logic dma_valid, // DMA request
    input wire logic dma_write, // DMA write
    input wire logic [31:0] dma_addr, // DMA address
    input wire logic [31:0] dma_wdata, // DMA write data
    output logic dma_ready, // DMA request taken
    output logic [31:0] dma_rdata, // DMA read data
    output logic dma_rvalid, // DMA read data valid
    output logic dma_err, // DMA unmapped access
    input wire logic [sbr_pkg::GPIO_PINS-1:0] gpio_pins, // GPIO levels A-H
    input wire logic boot_check_dis, // Boot pin check disable
    input wire logic boot_pin_pol, // Boot pin polarity
    input wire logic [sbr_pkg::PIN_SEL_BITS-1:0] boot_pin_sel, // Boot pin index
    output logic boot_vec_req, // Fetch reset-vector word from flash
    output logic [31:0] boot_vec_addr, // Flash address for fetch
    input wire logic boot_vec_valid, // Flash word returned
    input wire logic [31:0] boot_vec_data, // Flash word
    output logic boot_done, // Boot decision made
    output logic rom_at_zero, // ROM mapped at address zero
    output logic core_run_app, // Core loads SP and PC from flash
    output logic [31:0] core_sp_addr, // Stack pointer load address
    output logic [31:0] core_pc_addr // Program counter load address
);
    ////////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [31:0] bank_even [sbr_pkg::BANK_WORDS];
    logic [31:0] bank_odd [sbr_pkg::BANK_WORDS];
    logic [1:0] last_wr_bank_r; // Bit per bank written last cycle
    logic [31:0] cpu_rdata_r, dma_rdata_r;
    logic cpu_rvalid_r, dma_rvalid_r, cpu_err_r, dma_err_r;
    logic [1:0] gpio_s1_r;
    logic [sbr_pkg::GPIO_PINS-1:0] gpio_m_r, gpio_s_r;
    logic remap_r; // High: ROM at zero
    sbr_pkg::sbr_boot_state_type boot_r;

    ////////////////////////////////////////////////////////////////////////////
    // Per-master decode
    typedef struct packed {
        logic sram;
        logic alias_hit;
        logic rom;
        logic flash;
        logic bank;
        logic [sbr_pkg::BANK_IDX_BITS-1:0] idx;
        logic [4:0] bit_no;
    } sbr_dec_type;

    // Decode one master's address into window hits and bank slot
    // Alias and plain SRAM share the bank and index fields
    function automatic sbr_dec_type sbr_decode(input logic [31:0] a, input logic is_cpu, input logic rmap);
        sbr_dec_type d;
        logic [sbr_pkg::SRAM_ADDR_BITS-1:0] byte_off;
        d = '0;
        byte_off = '0;
        // Direct SRAM window
        d.sram = (a[31:sbr_pkg::SRAM_ADDR_BITS] == sbr_pkg::SRAM_BASE[31:sbr_pkg::SRAM_ADDR_BITS]);
        // Alias window, byte offset*32 plus bit*4
        d.alias_hit = (a[31:sbr_pkg::ALIAS_SPAN_BITS] == sbr_pkg::ALIAS_BASE[31:sbr_pkg::ALIAS_SPAN_BITS]);
        if (d.alias_hit) begin
            byte_off = a[sbr_pkg::ALIAS_BYTE_LSB +: sbr_pkg::SRAM_ADDR_BITS];
            d.bit_no = {byte_off[1:0], a[sbr_pkg::ALIAS_BIT_LSB +: 3]};
        end else begin
            byte_off = a[sbr_pkg::SRAM_ADDR_BITS-1:0];
        end
        d.bank = byte_off[2];
        d.idx = byte_off[sbr_pkg::SRAM_ADDR_BITS-1:3];
        // ROM and flash only on the core bus
        d.rom = is_cpu && ((a[31:sbr_pkg::ROM_SPAN_BITS] == sbr_pkg::ROM_BASE[31:sbr_pkg::ROM_SPAN_BITS])
            || (rmap && a[31:sbr_pkg::ROM_SPAN_BITS] == 8'h00));
        d.flash = is_cpu && !rmap && a[31:sbr_pkg::ROM_SPAN_BITS] == 8'h00;
        return d;
    endfunction

    sbr_dec_type cdec, ddec;
    assign cdec = sbr_decode(cpu_addr, 1'b1, remap_r);
    assign ddec = sbr_decode(dma_addr, 1'b0, remap_r);

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration: core first; DMA only if other bank or core idle
    logic c_mem, d_mem, c_stall, d_stall, c_go, d_go;
    assign c_mem = cpu_valid && (cdec.sram || cdec.alias_hit);
    assign d_mem = dma_valid && (ddec.sram || ddec.alias_hit);
    // Bank arrays are flops; the stall keeps the banks' own timing
    // Alias access counts as a bank write, it modifies in place
    // Read or alias access hitting the bank written last cycle waits once
    assign c_stall = c_mem && (!cpu_write || cdec.alias_hit) && last_wr_bank_r[cdec.bank];
    assign d_stall = d_mem && (!dma_write || ddec.alias_hit) && last_wr_bank_r[ddec.bank];
    assign c_go = c_mem && !c_stall;
    // DMA yields a shared bank to the core
    assign d_go = d_mem && !d_stall && !(c_mem && cdec.bank == ddec.bank);
    assign cpu_ready = cpu_valid && !(c_mem && !c_go);
    assign dma_ready = dma_valid && !(d_mem && !d_go);
    assign cpu_rom_sel = cpu_valid && cdec.rom;
    assign cpu_flash_sel = cpu_valid && cdec.flash;

    ////////////////////////////////////////////////////////////////////////////
    // Bank write tracking
    // One bit per bank, only the previous cycle counts
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            last_wr_bank_r <= 2'b00;
        end else begin
            last_wr_bank_r <= 2'b00;
            if (c_go && (cpu_write || cdec.alias_hit)) begin
                last_wr_bank_r[cdec.bank] <= 1'b1;
            end
            if (d_go && (dma_write || ddec.alias_hit)) begin
                last_wr_bank_r[ddec.bank] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bank arrays, alias does the bit update in place
    // Alias write sets or clears one bit, the rest of the word stays
    // Alias read writes the word back unchanged
    function automatic logic [31:0] sbr_merge(input logic [31:0] old, input sbr_dec_type d,
                                              input logic wr, input logic [31:0] wd);
        logic [31:0] r;
        r = old;
        if (d.alias_hit) begin
            if (wr) begin
                r[d.bit_no] = wd[0];
            end
        end else if (wr) begin
            r = wd;
        end
        return r;
    endfunction

    // Core and DMA never share a bank in one cycle
    always_ff @(posedge mclk) begin
        if (c_go && (cpu_write || cdec.alias_hit)) begin
            if (cdec.bank) begin
                bank_odd[cdec.idx] <= sbr_merge(bank_odd[cdec.idx], cdec, cpu_write, cpu_wdata);
            end else begin
                bank_even[cdec.idx] <= sbr_merge(bank_even[cdec.idx], cdec, cpu_write, cpu_wdata);
            end
        end
        if (d_go && (dma_write || ddec.alias_hit)) begin
            if (ddec.bank) begin
                bank_odd[ddec.idx] <= sbr_merge(bank_odd[ddec.idx], ddec, dma_write, dma_wdata);
            end else begin
                bank_even[ddec.idx] <= sbr_merge(bank_even[ddec.idx], ddec, dma_write, dma_wdata);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data paths
    // Alias read returns the bit in bit 0, zeros above
    function automatic logic [31:0] sbr_rd(input logic [31:0] w, input sbr_dec_type d);
        if (d.alias_hit) begin
            return {31'h0000_0000, w[d.bit_no]};
        end
        return w;
    endfunction

    // Core read data, valid and error pulse
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpu_rdata_r <= 32'h0000_0000;
            cpu_rvalid_r <= 1'b0;
            cpu_err_r <= 1'b0;
        end else begin
            cpu_rvalid_r <= c_go && !cpu_write;
            cpu_err_r <= cpu_valid && !c_mem && !cdec.rom && !cdec.flash;
            if (c_go && !cpu_write) begin
                cpu_rdata_r <= sbr_rd(cdec.bank ? bank_odd[cdec.idx] : bank_even[cdec.idx], cdec);
            end
        end
    end

    // DMA read data; ROM and flash answer with an error
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dma_rdata_r <= 32'h0000_0000;
            dma_rvalid_r <= 1'b0;
            dma_err_r <= 1'b0;
        end else begin
            dma_rvalid_r <= d_go && !dma_write;
            dma_err_r <= dma_valid && !d_mem;
            if (d_go && !dma_write) begin
                dma_rdata_r <= sbr_rd(ddec.bank ? bank_odd[ddec.idx] : bank_even[ddec.idx], ddec);
            end
        end
    end

    // Data outputs straight from flops
    assign cpu_rdata = cpu_rdata_r;
    assign cpu_rvalid = cpu_rvalid_r;
    assign cpu_err = cpu_err_r;
    assign dma_rdata = dma_rdata_r;
    assign dma_rvalid = dma_rvalid_r;
    assign dma_err = dma_err_r;

    ////////////////////////////////////////////////////////////////////////////
    // GPIO synchroniser, two stages
    // Pins are asynchronous; only the second stage is read
    always_ff @(posedge mclk) begin
        gpio_m_r <= gpio_pins;
        gpio_s_r <= gpio_m_r;
    end

    logic pin_level;
    assign pin_level = gpio_s_r[boot_pin_sel];

    ////////////////////////////////////////////////////////////////////////////
    // Boot remap sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            boot_r <= sbr_pkg::SBR_BOOT_CLEAR;
            // Remap set in reset so first fetches hit ROM
            remap_r <= sbr_pkg::BOOT_ROM_SEL;
            gpio_s1_r <= 2'b00;
        end else begin
            // Two cycles so the pin level has passed both stages
            gpio_s1_r <= {gpio_s1_r[0], 1'b1};
            unique case (boot_r)
                sbr_pkg::SBR_BOOT_CLEAR: begin
                    // Wait for synchroniser to fill, then clear remap
                    if (gpio_s1_r[1]) begin
                        remap_r <= sbr_pkg::BOOT_FLASH_SEL;
                        boot_r <= sbr_pkg::SBR_BOOT_PIN;
                    end
                end
                sbr_pkg::SBR_BOOT_PIN: begin
                    if (!boot_check_dis && pin_level == boot_pin_pol) begin
                        remap_r <= sbr_pkg::BOOT_ROM_SEL;
                        boot_r <= sbr_pkg::SBR_BOOT_LOADER;
                    end else begin
                        boot_r <= sbr_pkg::SBR_BOOT_VEC_REQ;
                    end
                end
                sbr_pkg::SBR_BOOT_VEC_REQ: begin
                    boot_r <= sbr_pkg::SBR_BOOT_VEC_WAIT;
                end
                sbr_pkg::SBR_BOOT_VEC_WAIT: begin
                    if (boot_vec_valid) begin
                        if (boot_vec_data == sbr_pkg::ERASED_WORD) begin
                            remap_r <= sbr_pkg::BOOT_ROM_SEL;
                            boot_r <= sbr_pkg::SBR_BOOT_LOADER;
                        end else begin
                            boot_r <= sbr_pkg::SBR_BOOT_APP;
                        end
                    end
                end
                // Loader and app are final until the next reset
                sbr_pkg::SBR_BOOT_LOADER: begin
                    boot_r <= sbr_pkg::SBR_BOOT_LOADER;
                end
                sbr_pkg::SBR_BOOT_APP: begin
                    boot_r <= sbr_pkg::SBR_BOOT_APP;
                end
                default: begin
                    boot_r <= sbr_pkg::SBR_BOOT_CLEAR;
                end
            endcase
        end
    end

    // Boot outputs
    assign boot_vec_req = (boot_r == sbr_pkg::SBR_BOOT_VEC_REQ);
    assign boot_vec_addr = sbr_pkg::RESET_VECTOR_ADDR;
    assign boot_done = (boot_r == sbr_pkg::SBR_BOOT_LOADER) || (boot_r == sbr_pkg::SBR_BOOT_APP);
    assign rom_at_zero = remap_r;
    assign core_run_app = (boot_r == sbr_pkg::SBR_BOOT_APP);
    // SP and PC load from the first two flash words
    assign core_sp_addr = sbr_pkg::STACK_WORD_ADDR;
    assign core_pc_addr = sbr_pkg::RESET_VECTOR_ADDR;
endmodule

// ===== hw/sbr_pkg.sv
// Package of constants for the SRAM, bit-band and boot remap front end
package sbr_pkg;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ROM_BASE = 32'h0100_0000;
    localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
    localparam logic [31:0] STACK_WORD_ADDR = 32'h0000_0000;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam int SRAM_ADDR_BITS = 15;
    localparam int BANK_WORDS = 4096;
    localparam int BANK_IDX_BITS = 12;
    localparam int ALIAS_SPAN_BITS = 20;
    localparam int ROM_SPAN_BITS = 24;
    localparam int ALIAS_BIT_LSB = 2;
    localparam int ALIAS_BYTE_LSB = 5;
    localparam int GPIO_PINS = 64;
    localparam int PIN_SEL_BITS = 6;
    localparam logic BOOT_ROM_SEL = 1'b1;
    localparam logic BOOT_FLASH_SEL = 1'b0;
    typedef enum logic [2:0] {
        SBR_BOOT_CLEAR = 3'b000,
        SBR_BOOT_PIN = 3'b001,
        SBR_BOOT_VEC_REQ = 3'b010,
        SBR_BOOT_VEC_WAIT = 3'b011,
        SBR_BOOT_LOADER = 3'b100,
        SBR_BOOT_APP = 3'b101
    } sbr_boot_state_type;
endpackage

// ===== verif/sbr_asserts.sv
// Concurrent checks on the memory front end ports
`timescale 1ns/1ns
module sbr_asserts (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cpu_valid, // Core request
    input wire logic cpu_write, // Core write
    input wire logic [31:0] cpu_addr, // Core address
    input wire logic cpu_ready, // Core taken
    input wire logic cpu_rvalid, // Core data valid
    input wire logic cpu_rom_sel, // Core to ROM
    input wire logic dma_valid, // DMA request
    input wire logic [31:0] dma_addr, // DMA address
    input wire logic dma_ready, // DMA taken
    input wire logic dma_err, // DMA error
    input wire logic boot_vec_valid, // Flash answer
    input wire logic [31:0] boot_vec_data, // Flash word
    input wire logic boot_done, // Boot made
    input wire logic rom_at_zero, // ROM at zero
    input wire logic core_run_app, // App start
    input wire logic [31:0] core_sp_addr, // SP address
    input wire logic [31:0] core_pc_addr // PC address
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Core address hits plain SRAM
    logic c_sram;
    assign c_sram = cpu_addr[31:15] == 17'h4000;
    // Bus timing and decode
    sram_rd_ans_a: assert property (cpu_valid && !cpu_write && cpu_ready && c_sram |=> cpu_rvalid)
        else $error("sram read gave no data");
    same_bank_stall_a: assert property (cpu_valid && !cpu_write && c_sram
        && $past(cpu_valid && cpu_ready && cpu_write && c_sram) && cpu_addr[2] == $past(cpu_addr[2])
        |-> !cpu_ready) else $error("no stall");
    stall_once_a: assert property (cpu_valid && !cpu_ready |=> cpu_ready)
        else $error("stall longer than one cycle");
    other_bank_go_a: assert property (cpu_valid && !cpu_write && c_sram
        && $past(cpu_valid && cpu_ready && cpu_write && c_sram) && cpu_addr[2] != $past(cpu_addr[2])
        && !$past(dma_valid) |-> cpu_ready) else $error("wait");
    dma_no_rom_a: assert property (dma_valid && dma_ready && dma_addr[31:24] == 8'h01 |=> dma_err)
        else $error("dma reached rom");
    rom_decode_a: assert property (cpu_valid && cpu_addr[31:24] == 8'h01 |-> cpu_rom_sel)
        else $error("rom not selected");
    // Boot sequence
    boot_clear_a: assert property ($fell(sys_rst) |-> rom_at_zero ##[1:3] !rom_at_zero)
        else $error("remap not cleared at boot");
    erased_map_a: assert property (boot_vec_valid && boot_vec_data == 32'hFFFF_FFFF && !boot_done
        |-> ##[1:3] boot_done && rom_at_zero) else $error("erased flash not caught");
    app_entry_a: assert property (core_run_app |-> !rom_at_zero && core_sp_addr == 32'h0000_0000
        && core_pc_addr == 32'h0000_0004) else $error("bad app entry");
    cover property (cpu_valid && !cpu_ready);
    cover property (core_run_app);
    cover property (dma_err);
endmodule
bind sbr_sram_bitband_boot_remap sbr_asserts sbr_asserts_inst (.mclk, .sys_rst, .cpu_valid, .cpu_write, .cpu_addr,
    .cpu_ready, .cpu_rvalid, .cpu_rom_sel, .dma_valid, .dma_addr, .dma_ready, .dma_err, .boot_vec_valid,
    .boot_vec_data, .boot_done, .rom_at_zero, .core_run_app, .core_sp_addr, .core_pc_addr);

// ===== verif/sbr_flash_model.sv
// Flash side model answering the boot vector fetch
`timescale 1ns/1ns
module sbr_flash_model (
    input wire logic mclk, // Clock
    input wire logic req, // Fetch request
    input wire logic [31:0] addr, // Fetch address
    input wire logic [31:0] vec_word, // Stored vector word
    input wire logic [3:0] lat, // Answer delay
    output logic valid, // Word returned
    output logic [31:0] data // Word
);
    // Answer after lat cycles; wrong address, or idle after the first answer, shows the inverted word (zero before it)
    initial begin
        valid = 1'b0;
        data = 32'h0000_0000;
        forever begin
            @(posedge mclk);
            if (req) begin
                repeat (lat) @(posedge mclk);
                valid <= 1'b1;
                data <= (addr == 32'h0000_0004) ? vec_word : ~vec_word;
                @(posedge mclk);
                valid <= 1'b0;
                data <= ~vec_word;
            end
        end
    end
endmodule

// ===== verif/testbench.sv
// Directed tests of SRAM banks, alias access and boot choice
`timescale 1ns/1ns
module testbench;
    logic mclk, sys_rst, cpu_valid, cpu_write, dma_valid, dma_write, boot_check_dis, boot_pin_pol;
    logic cpu_ready, cpu_rvalid, cpu_err, cpu_rom_sel, cpu_flash_sel, dma_ready, dma_rvalid, dma_err;
    logic boot_vec_req, boot_vec_valid, boot_done, rom_at_zero, core_run_app, at_edge;
    logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, dma_addr, dma_wdata, dma_rdata, boot_vec_addr, boot_vec_data;
    logic [31:0] core_sp_addr, core_pc_addr, vec_word;
    logic [sbr_pkg::GPIO_PINS-1:0] gpio_pins;
    logic [5:0] boot_pin_sel;
    logic [3:0] lat;
    int err_count, total_checks;
    sbr_sram_bitband_boot_remap sbr_sram_bitband_boot_remap_inst (.mclk, .sys_rst, .cpu_valid, .cpu_write, .cpu_addr,
        .cpu_wdata, .cpu_ready, .cpu_rdata, .cpu_rvalid, .cpu_err, .cpu_rom_sel, .cpu_flash_sel, .dma_valid,
        .dma_write, .dma_addr, .dma_wdata, .dma_ready, .dma_rdata, .dma_rvalid, .dma_err, .gpio_pins, .boot_check_dis,
        .boot_pin_pol, .boot_pin_sel, .boot_vec_req, .boot_vec_addr, .boot_vec_valid, .boot_vec_data, .boot_done,
        .rom_at_zero, .core_run_app, .core_sp_addr, .core_pc_addr);
    sbr_flash_model sbr_flash_model_inst (.mclk, .req(boot_vec_req), .addr(boot_vec_addr), .vec_word, .lat,
        .valid(boot_vec_valid), .data(boot_vec_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One access; reads check stall count, outcome and data
    task automatic acc(input logic m, input logic wr, input logic [31:0] a, input logic [31:0] d,
        input int st_exp, input logic [1:0] o, input logic [31:0] exp);
        int st;
        logic rdy;
        st = 0;
        rdy = 1'b0;
        if (!at_edge) @(posedge mclk);
        if (m) {dma_valid, dma_write, dma_addr, dma_wdata, cpu_valid} <= {1'b1, wr, a, d, 1'b0};
        else {cpu_valid, cpu_write, cpu_addr, cpu_wdata, dma_valid} <= {1'b1, wr, a, d, 1'b0};
        while (rdy !== 1'b1 && st < 9) begin
            @(negedge mclk);
            rdy = m ? dma_ready : cpu_ready;
            @(posedge mclk);
            st = st + ((rdy === 1'b1) ? 0 : 1);
        end
        at_edge = 1'b1;
        if (!wr) begin
            if (m) dma_valid <= 1'b0;
            else cpu_valid <= 1'b0;
            @(negedge mclk);
            at_edge = 1'b0;
            chk(32'(st), 32'(st_exp));
            chk(m ? {30'h0, dma_err, dma_rvalid} : {30'h0, cpu_err, cpu_rvalid}, 32'(o));
            if (o == 2'b01) chk(m ? dma_rdata : cpu_rdata, exp);
        end
    endtask
    // Configure boot, reset for 8 cycles, wait for the decision
    task automatic boot(input logic dis, input logic pol, input logic [5:0] sel, input logic pin,
        input logic [31:0] w, input logic [3:0] l);
        @(posedge mclk);
        {boot_check_dis, boot_pin_pol, boot_pin_sel, vec_word, lat, sys_rst} <= {dis, pol, sel, w, l, 1'b1};
        gpio_pins <= 64'(pin) << sel;
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        chk(32'(rom_at_zero), 32'h0000_0001);
        @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 40 && boot_done !== 1'b1; i++) @(negedge mclk);
        chk(32'(boot_done), 32'h0000_0001);
    endtask
    // One core fetch, checks routing to ROM or flash
    task automatic sel_chk(input logic [31:0] a, input logic [1:0] exp);
        @(posedge mclk);
        {cpu_valid, cpu_write, cpu_addr} <= {1'b1, 1'b0, a};
        @(negedge mclk);
        chk(32'({cpu_rom_sel, cpu_flash_sel}), 32'(exp));
        @(posedge mclk);
        cpu_valid <= 1'b0;
    endtask
    // Clock at 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Watchdog
    initial begin
        #100_000;
        err_count++;
        close_out;
    end
    // Main sequence
    initial begin
        {sys_rst, cpu_valid, cpu_write, dma_valid, dma_write, at_edge} = 6'b10_0000;
        {cpu_addr, cpu_wdata, dma_addr, dma_wdata, vec_word} = '0;
        {gpio_pins, boot_pin_sel, lat, boot_check_dis, boot_pin_pol} = '0;
        boot_pin_pol = 1'b1;
        boot(1'b0, 1'b1, 6'd45, 1'b1, 32'h0000_1234, 4'd0);
        chk(32'({rom_at_zero, core_run_app}), 32'h0000_0002);
        sel_chk(32'h0000_0000, 2'b10);
        boot(1'b0, 1'b1, 6'd63, 1'b0, 32'hFFFF_FFFF, 4'd3);
        chk(32'({rom_at_zero, core_run_app}), 32'h0000_0002);
        chk(boot_vec_addr, 32'h0000_0004);
        boot(1'b0, 1'b0, 6'd10, 1'b0, 32'h0000_1234, 4'd2);
        chk(32'({rom_at_zero, core_run_app}), 32'h0000_0002);
        boot(1'b1, 1'b1, 6'd3, 1'b1, 32'h0000_1234, 4'd5);
        chk(32'({rom_at_zero, core_run_app}), 32'h0000_0001);
        chk(core_sp_addr, 32'h0000_0000);
        chk(core_pc_addr, 32'h0000_0004);
        sel_chk(32'h0000_0000, 2'b01);
        sel_chk(32'h0100_0000, 2'b10);
        $display("boot tests done");
        acc(1'b0, 1'b1, 32'h2000_0000, 32'hA5A5_0001, 0, 2'b00, 32'h0);
        acc(1'b0, 1'b0, 32'h2000_0000, 32'h0, 1, 2'b01, 32'hA5A5_0001);
        acc(1'b0, 1'b1, 32'h2000_0004, 32'h5A5A_0002, 0, 2'b00, 32'h0);
        acc(1'b0, 1'b0, 32'h2000_0000, 32'h0, 0, 2'b01, 32'hA5A5_0001);
        acc(1'b0, 1'b1, 32'h2000_1000, 32'h0000_00F0, 0, 2'b00, 32'h0);
        acc(1'b0, 1'b1, 32'h2202_000C, 32'h0000_0001, 0, 2'b00, 32'h0);
        acc(1'b0, 1'b0, 32'h2202_000C, 32'h0, 1, 2'b01, 32'h0000_0001);
        acc(1'b0, 1'b0, 32'h2000_1000, 32'h0, 0, 2'b01, 32'h0000_00F8);
        acc(1'b0, 1'b1, 32'h2202_0010, 32'hFFFF_FFFE, 0, 2'b00, 32'h0);
        acc(1'b1, 1'b0, 32'h2000_1000, 32'h0, 1, 2'b01, 32'h0000_00E8);
        acc(1'b0, 1'b0, 32'h2202_0000, 32'h0, 0, 2'b01, 32'h0000_0000);
        acc(1'b1, 1'b0, 32'h2000_0004, 32'h0, 0, 2'b01, 32'h5A5A_0002);
        acc(1'b1, 1'b0, 32'h0100_0000, 32'h0, 0, 2'b10, 32'h0);
        acc(1'b0, 1'b0, 32'h0100_0000, 32'h0, 0, 2'b00, 32'h0);
        acc(1'b0, 1'b0, 32'h3000_0000, 32'h0, 0, 2'b10, 32'h0);
        $display("memory tests done");
        close_out;
    end
endmodule
